// *** hw/pfr_fault_resp.sv ***
// Fault response, status flags, alert and retry control for eight channels
`timescale 1ns/10ps
module pfr_fault_resp
  import pfr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                cmd_wr,
  input  wire logic                cmd_rd,
  input  wire logic [7:0]          cmd_code,
  input  wire logic [7:0]          cmd_data,
  output      logic [7:0]          rd_data,
  input  wire logic                adc_valid,
  input  wire logic                adc_ot,
  input  wire logic                adc_ut,
  input  wire logic                adc_vin_ov,
  input  wire logic                adc_vin_uv,
  input  wire logic [PFR_NCH-1:0]  ton_max_fault,
  input  wire logic [PFR_NCH-1:0]  chan_seq_mode,
  input  wire logic [PFR_NCH-1:0]  chan_on_cmd,
  input  wire logic [PFR_NCH-1:0]  chan_is_off,
  input  wire logic [2:0]          retry_limit,
  input  wire logic [PFR_NCH-1:0]  channel_on_pin,
  input  wire logic                bias_ok,
  output      logic [PFR_NCH-1:0]  chan_off_now,
  output      logic [PFR_NCH-1:0]  chan_seq_off,
  output      logic [PFR_NCH-1:0]  chan_restart,
  output      logic [PFR_NCH-1:0]  chan_latched,
  output      logic [15:0]         status_word,
  output      logic [7:0]          status_input,
  output      logic [7:0]          status_temp,
  output      logic [PFR_NCH-1:0]  ton_max_flags,
  output      logic                host_alert_line_o,
  output      logic                host_alert_line_oe
);

  typedef struct packed {
    logic [7:0]                react_ot;
    logic [7:0]                react_ut;
    logic [7:0]                react_ov;
    logic [7:0]                react_uv;
    logic [7:0]                react_ton;
    logic [7:0]                rdat;
    logic [PFR_NCH-1:0]        pin_s1;
    logic [PFR_NCH-1:0]        pin_s2;
    logic [PFR_NCH-1:0]        pin_s3;
    logic [PFR_NCH-1:0]        pin_ag;
    logic [2:0]                bias_s;
    logic                      bias_ag;
    pfr_ch_t [PFR_NCH-1:0]     ch;
    logic [PFR_NCH-1:0][2:0]   ret;
    logic [PFR_NCH-1:0][2:0]   cnt;
    logic [PFR_NCH-1:0]        off_p;
    logic [PFR_NCH-1:0]        seq_p;
    logic [PFR_NCH-1:0]        rst_p;
    logic [15:0]               sw;
    logic [7:0]                sin;
    logic [7:0]                stp;
    logic [PFR_NCH-1:0]        svo;
    logic                      alert;
  } pfr_state_t;

  pfr_state_t state_ff;
  pfr_state_t nxt_state;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic                clr;
    logic                ot_e;
    logic                ut_e;
    logic                ov_e;
    logic                uv_e;
    logic                adc_stop;
    logic [2:0]          adc_ret;
    logic [15:0]         sw_set;
    logic [7:0]          in_set;
    logic [7:0]          tp_set;
    logic [PFR_NCH-1:0]  tog;
    logic                bias_back;
    logic                stop;
    logic [2:0]          rret;
    nxt_state = state_ff;
    nxt_state.off_p = '0;
    nxt_state.seq_p = '0;
    nxt_state.rst_p = '0;
    clr    = cmd_wr && (cmd_code == PFR_CMD_CLEAR);
    // Readings act in the cycle they arrive
    ot_e   = adc_valid & adc_ot;
    ut_e   = adc_valid & adc_ut;
    ov_e   = adc_valid & adc_vin_ov;
    uv_e   = adc_valid & adc_vin_uv;
    // Last active fault in this order supplies the retry field
    adc_stop = 1'b0;
    adc_ret  = 3'h0;
    stop     = 1'b0;
    if (uv_e && state_ff.react_uv[PFR_ACT_MSB:PFR_ACT_LSB] != 2'h0) begin
      adc_stop = 1'b1;
      adc_ret  = state_ff.react_uv[PFR_RET_MSB:PFR_RET_LSB];
    end
    if (ov_e && state_ff.react_ov[PFR_ACT_MSB:PFR_ACT_LSB] != 2'h0) begin
      adc_stop = 1'b1;
      adc_ret  = state_ff.react_ov[PFR_RET_MSB:PFR_RET_LSB];
    end
    if (ut_e && state_ff.react_ut[PFR_ACT_MSB:PFR_ACT_LSB] != 2'h0) begin
      adc_stop = 1'b1;
      adc_ret  = state_ff.react_ut[PFR_RET_MSB:PFR_RET_LSB];
    end
    if (ot_e && state_ff.react_ot[PFR_ACT_MSB:PFR_ACT_LSB] != 2'h0) begin
      adc_stop = 1'b1;
      adc_ret  = state_ff.react_ot[PFR_RET_MSB:PFR_RET_LSB];
    end
    // Status flags, set wins over clear
    sw_set = '0;
    in_set = '0;
    tp_set = '0;
    sw_set[PFR_SW_TEMP]   = ot_e | ut_e;
    sw_set[PFR_SW_VIN_UV] = uv_e;
    sw_set[PFR_SW_INPUT]  = ov_e | uv_e;
    sw_set[PFR_SW_HIGH]   = ov_e | (|ton_max_fault);
    sw_set[PFR_SW_VOUT]   = |ton_max_fault;
    in_set[PFR_IN_OV]     = ov_e;
    in_set[PFR_IN_UV]     = uv_e;
    tp_set[PFR_TP_OT]     = ot_e;
    tp_set[PFR_TP_UT]     = ut_e;
    nxt_state.sw  = (clr ? 16'h0000 : state_ff.sw) | sw_set;
    nxt_state.sin = (clr ? 8'h00 : state_ff.sin) | in_set;
    nxt_state.stp = (clr ? 8'h00 : state_ff.stp) | tp_set;
    nxt_state.svo = (clr ? '0 : state_ff.svo) | ton_max_fault;
    nxt_state.alert = (state_ff.alert & ~clr) | ot_e | ut_e | ov_e | uv_e
                      | (|ton_max_fault);
    // Reaction settings; the delay field is fixed
    if (cmd_wr) begin
      if (cmd_code == PFR_CMD_OT) begin
        nxt_state.react_ot = {cmd_data[7:3], PFR_DELAY_FIXED};
      end else if (cmd_code == PFR_CMD_UT) begin
        nxt_state.react_ut = {cmd_data[7:3], PFR_DELAY_FIXED};
      end else if (cmd_code == PFR_CMD_VIN_OV) begin
        nxt_state.react_ov = {cmd_data[7:3], PFR_DELAY_FIXED};
      end else if (cmd_code == PFR_CMD_VIN_UV) begin
        nxt_state.react_uv = {cmd_data[7:3], PFR_DELAY_FIXED};
      end else if (cmd_code == PFR_CMD_TON_MAX) begin
        nxt_state.react_ton = {cmd_data[7:3], PFR_DELAY_FIXED};
      end
    end
    if (cmd_rd) begin
      if (cmd_code == PFR_CMD_OT) begin
        nxt_state.rdat = state_ff.react_ot;
      end else if (cmd_code == PFR_CMD_UT) begin
        nxt_state.rdat = state_ff.react_ut;
      end else if (cmd_code == PFR_CMD_VIN_OV) begin
        nxt_state.rdat = state_ff.react_ov;
      end else if (cmd_code == PFR_CMD_VIN_UV) begin
        nxt_state.rdat = state_ff.react_uv;
      end else if (cmd_code == PFR_CMD_TON_MAX) begin
        nxt_state.rdat = state_ff.react_ton;
      end else begin
        nxt_state.rdat = 8'h00;
      end
    end
    // Pins: a change counts once stages two and three agree
    nxt_state.pin_s1 = channel_on_pin;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.pin_s3 = state_ff.pin_s2;
    nxt_state.pin_ag = state_ff.pin_ag ^ ((state_ff.pin_s2 ^ state_ff.pin_ag)
                       & ~(state_ff.pin_s2 ^ state_ff.pin_s3));
    tog = nxt_state.pin_ag ^ state_ff.pin_ag;
    nxt_state.bias_s = {state_ff.bias_s[1:0], bias_ok};
    if (state_ff.bias_s[1] == state_ff.bias_s[2]) begin
      nxt_state.bias_ag = state_ff.bias_s[2];
    end
    bias_back = nxt_state.bias_ag & ~state_ff.bias_ag;
    // Per-channel latch and retry
    rret = state_ff.react_ton[PFR_RET_MSB:PFR_RET_LSB];
    for (int i = 0; i < PFR_NCH; i++) begin
      logic       tstop;
      tstop = ton_max_fault[i]
              && state_ff.react_ton[PFR_ACT_MSB:PFR_ACT_LSB] != 2'h0;
      stop  = adc_stop | tstop;
      case (state_ff.ch[i])
        PFR_CH_RUN: begin
          if (stop) begin
            nxt_state.ch[i]    = PFR_CH_LATCH;
            nxt_state.ret[i]   = tstop ? rret : adc_ret;
            nxt_state.off_p[i] = ~chan_seq_mode[i];
            nxt_state.seq_p[i] = chan_seq_mode[i];
          end
          if (chan_on_cmd[i] || tog[i] || bias_back) begin
            nxt_state.cnt[i] = 3'h0;
          end
        end
        PFR_CH_LATCH: begin
          if (chan_on_cmd[i] || tog[i] || bias_back) begin
            nxt_state.ch[i]  = PFR_CH_RUN;
            nxt_state.cnt[i] = 3'h0;
          end else if (stop || !state_ff.bias_ag || !state_ff.pin_ag[i]) begin
            nxt_state.ret[i] = 3'h0;
          end else if (state_ff.ret[i] != 3'h0 && chan_is_off[i]
                       && state_ff.cnt[i] < retry_limit) begin
            nxt_state.ch[i]    = PFR_CH_RUN;
            nxt_state.rst_p[i] = 1'b1;
            nxt_state.cnt[i]   = state_ff.cnt[i] + 3'h1;
          end
        end
        default: nxt_state.ch[i] = PFR_CH_LATCH;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= '{react_ot: PFR_REACT_RST, react_ut: PFR_REACT_RST,
                    react_ov: PFR_REACT_RST, react_uv: PFR_REACT_RST,
                    react_ton: PFR_REACT_RST, ch: '{default: PFR_CH_RUN},
                    default: '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rd_data            = state_ff.rdat;
  assign chan_off_now       = state_ff.off_p;
  assign chan_seq_off       = state_ff.seq_p;
  assign chan_restart       = state_ff.rst_p;
  assign status_word        = state_ff.sw;
  assign status_input       = state_ff.sin;
  assign status_temp        = state_ff.stp;
  assign ton_max_flags      = state_ff.svo;
  assign host_alert_line_o  = 1'b0;
  assign host_alert_line_oe = state_ff.alert;
  for (genvar g = 0; g < PFR_NCH; g++) begin : g_lat
    assign chan_latched[g] = (state_ff.ch[g] == PFR_CH_LATCH);
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  adc_alert_a: assert property (adc_valid && adc_ot |=> host_alert_line_oe)
    else $error("alert not raised on temperature fault");
  ot_flag_a: assert property (adc_valid && adc_ot |=> status_temp[PFR_TP_OT]
                              && status_word[PFR_SW_TEMP])
    else $error("temperature flags not set");
  ton_flag_a: assert property (ton_max_fault[0] |=> ton_max_flags[0]
                               && status_word[PFR_SW_VOUT] && host_alert_line_oe)
    else $error("start-up timeout flags not set");
  keep_run_a: assert property (adc_valid && state_ff.react_ot[7:6] == 2'h0
                               && !adc_ut && !adc_vin_ov && !adc_vin_uv
                               && ton_max_fault == '0 && !chan_latched[0]
                               |=> !chan_latched[0] && !chan_off_now[0])
    else $error("action zero shut a channel");
  shut_mode_a: assert property (ton_max_fault[1] && state_ff.react_ton[7:6] != 2'h0
                                && !chan_latched[1]
                                |=> chan_latched[1] && (chan_seq_off[1] == $past(chan_seq_mode[1]))
                                    && (chan_off_now[1] != chan_seq_off[1]))
    else $error("shutdown kind wrong");
  delay_fixed_a: assert property (cmd_rd |=> rd_data[2:0] == 3'h0)
    else $error("delay field not zero");
  no_retry_a: assert property (chan_latched[2] && state_ff.ret[2] == 3'h0
                               && !chan_on_cmd[2] |=> !chan_restart[2])
    else $error("restart with retry zero");
  retry_limit_a: assert property (chan_restart[3]
                                  |-> state_ff.cnt[3] <= retry_limit && state_ff.cnt[3] != 3'h0)
    else $error("restart beyond limit");
  clear_keep_a: assert property (chan_latched[4] && cmd_wr && cmd_code == PFR_CMD_CLEAR
                                 && !chan_on_cmd[4] && state_ff.ret[4] == 3'h0
                                 && state_ff.bias_ag && state_ff.pin_s2[4] == state_ff.pin_ag[4]
                                 |=> chan_latched[4])
    else $error("clear faults released a channel");
  bias_stop_a: assert property (!state_ff.bias_ag |=> !chan_restart[5])
    else $error("restart while bias lost");

  shut_c:    cover property (chan_off_now[0] ##[1:50] chan_restart[0]);
  seq_c:     cover property (chan_seq_off[1]);
  clear_c:   cover property (host_alert_line_oe ##1 !host_alert_line_oe);
endmodule : pfr_fault_resp

// *** hw/pfr_pkg.sv ***
// Constants for the ADC and start-up timeout fault response block
package pfr_pkg;
  localparam int          PFR_NCH          = 8;
  // Command codes of the reaction settings and of fault clearing
  localparam logic [7:0]  PFR_CMD_CLEAR    = 8'h03;
  localparam logic [7:0]  PFR_CMD_OT       = 8'h50;
  localparam logic [7:0]  PFR_CMD_UT       = 8'h54;
  localparam logic [7:0]  PFR_CMD_VIN_OV   = 8'h56;
  localparam logic [7:0]  PFR_CMD_VIN_UV   = 8'h5A;
  localparam logic [7:0]  PFR_CMD_TON_MAX  = 8'h63;
  // Field layout of a reaction byte
  localparam int          PFR_ACT_MSB      = 7;
  localparam int          PFR_ACT_LSB      = 6;
  localparam int          PFR_RET_MSB      = 5;
  localparam int          PFR_RET_LSB      = 3;
  localparam logic [2:0]  PFR_DELAY_FIXED  = 3'h0;
  localparam logic [7:0]  PFR_REACT_RST    = 8'h00;
  // Summary word bits
  localparam int          PFR_SW_VOUT      = 15;
  localparam int          PFR_SW_INPUT     = 13;
  localparam int          PFR_SW_VIN_UV    = 3;
  localparam int          PFR_SW_TEMP      = 2;
  localparam int          PFR_SW_HIGH      = 0;
  // Detail flag bits
  localparam int          PFR_IN_OV        = 7;
  localparam int          PFR_IN_UV        = 4;
  localparam int          PFR_TP_OT        = 7;
  localparam int          PFR_TP_UT        = 4;
  localparam int          PFR_VO_TON_MAX   = 2;
  typedef enum logic [1:0] {
    PFR_CH_RUN   = 2'b01,
    PFR_CH_LATCH = 2'b10
  } pfr_ch_t;
endpackage : pfr_pkg

// *** verif/pfr_fault_resp_tb.sv ***
// Self-checking testbench of the fault response block
`timescale 1ns/10ps
module pfr_fault_resp_tb;
  import pfr_pkg::*;
  logic              clk = 1'h0, rst_n = 1'h0, cmd_wr, cmd_rd, bias_ok = 1'h1, seen;
  logic              adc_valid = 1'h0, adc_ot = 1'h0, adc_ut = 1'h0;
  logic              adc_vin_ov = 1'h0, adc_vin_uv = 1'h0, host_alert_line_o, host_alert_line_oe;
  logic [7:0]        cmd_code, cmd_data, rd_data, status_input, status_temp, rv, mode;
  logic [15:0]       status_word;
  logic [2:0]        retry_limit = 3'h2;
  logic [PFR_NCH-1:0] ton_max_fault = 8'h00, chan_seq_mode = 8'h00, chan_on_cmd = 8'h00;
  logic [PFR_NCH-1:0] chan_is_off = 8'hFF, channel_on_pin = 8'hFF, chan_off_now;
  logic [PFR_NCH-1:0] chan_seq_off, chan_restart, chan_latched, ton_max_flags, snap_off, snap_seq;
  int                err_count = 0, n_tests = 0, ch;
  logic [7:0]        codes [5] = '{PFR_CMD_OT, PFR_CMD_UT, PFR_CMD_VIN_OV, PFR_CMD_VIN_UV,
                                   PFR_CMD_TON_MAX};

  pfr_fault_resp i_pfr_fault_resp (.clk(clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rd_data(rd_data), .adc_valid(adc_valid),
    .adc_ot(adc_ot), .adc_ut(adc_ut), .adc_vin_ov(adc_vin_ov), .adc_vin_uv(adc_vin_uv),
    .ton_max_fault(ton_max_fault), .chan_seq_mode(chan_seq_mode), .chan_on_cmd(chan_on_cmd),
    .chan_is_off(chan_is_off), .retry_limit(retry_limit), .channel_on_pin(channel_on_pin),
    .bias_ok(bias_ok), .chan_off_now(chan_off_now), .chan_seq_off(chan_seq_off),
    .chan_restart(chan_restart), .chan_latched(chan_latched), .status_word(status_word),
    .status_input(status_input), .status_temp(status_temp), .ton_max_flags(ton_max_flags),
    .host_alert_line_o(host_alert_line_o), .host_alert_line_oe(host_alert_line_oe));
  pfr_host_model i_pfr_host_model (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_data(cmd_data), .rd_data(rd_data));

  always #12.5 clk = ~clk;

  function automatic logic [15:0] exp_word(input int k);
    return (k < 2) ? 16'h0004 : ((k == 2) ? 16'h2000 : 16'h2008);
  endfunction : exp_word
  function automatic logic [7:0] exp_det(input int k, input logic temp);
    if (temp != (k < 2)) return 8'h00;
    return k[0] ? 8'h10 : 8'h80;
  endfunction : exp_det

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Index 0..3 raises one ADC verdict; a mask in ton raises start-up timeouts
  task automatic fire(input int k, input logic [7:0] ton);
    adc_valid = (k < 4);
    {adc_ot, adc_ut, adc_vin_ov, adc_vin_uv} = (k < 4) ? (4'h8 >> k) : 4'h0;
    ton_max_fault = ton;
    @(negedge clk);
    adc_valid = 1'h0;
    {adc_ot, adc_ut, adc_vin_ov, adc_vin_uv} = 4'h0;
    ton_max_fault = 8'h00;
    snap_off = chan_off_now;
    snap_seq = chan_seq_off;
  endtask : fire
  task automatic watch(input int n, input logic [7:0] mask);
    seen = 1'h0;
    repeat (n) begin
      @(negedge clk);
      seen = seen | (|(chan_restart & mask));
    end
  endtask : watch
  task automatic wait_free(input int c);
    for (int i = 0; i < 12 && chan_latched[c] !== 1'h0; i++) @(negedge clk);
    chk("latch_free", 16'h0000, {15'h0, chan_latched[c]});
  endtask : wait_free

  initial begin
    #100000;
    err_count++;
    end_of_test();
  end

  initial begin
    void'($urandom(97));
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    repeat (8) @(negedge clk);
    chk("latched_rst", 16'h0000, {8'h0, chan_latched});
    foreach (codes[i]) begin
      i_pfr_host_model.rd(codes[i], rv);
      chk("react_rst", {8'h0, PFR_REACT_RST}, {8'h0, rv});
      rv = 8'($urandom);
      i_pfr_host_model.wr(codes[i], rv);
      i_pfr_host_model.rd(codes[i], mode);
      chk("react_rw", {8'h0, rv & 8'hF8}, {8'h0, mode});
    end
    i_pfr_host_model.rd(8'h7E, rv);
    chk("unmapped", 16'h0000, {8'h0, rv});
    for (int k = 0; k < 4; k++) begin
      i_pfr_host_model.wr(codes[k], 8'h00);
      fire(k, 8'h00);
      chk("word", exp_word(k), status_word & 16'hFFFE);
      chk("temp", {8'h0, exp_det(k, 1'h1)}, {8'h0, status_temp});
      chk("input", {8'h0, exp_det(k, 1'h0)}, {8'h0, status_input});
      chk("alert", 16'h0002, {14'h0, host_alert_line_oe, host_alert_line_o});
      chk("no_off", 16'h0000, {snap_off, snap_seq});
      i_pfr_host_model.wr(PFR_CMD_CLEAR, 8'h00);
      chk("cleared", 16'h0000, status_word | {15'h0, host_alert_line_oe});
      mode = 8'($urandom);
      chan_seq_mode = mode;
      i_pfr_host_model.wr(codes[k], {2'(k % 3 + 1), 3'h0, 3'($urandom)});
      fire(k, 8'h00);
      chk("off_now", {8'h0, ~mode}, {8'h0, snap_off});
      chk("seq_off", {8'h0, mode}, {8'h0, snap_seq});
      watch(8, 8'hFF);
      chk("no_retry", 16'h0000, {15'h0, seen});
      i_pfr_host_model.wr(PFR_CMD_CLEAR, 8'h00);
      chk("still_off", 16'h00FF, {8'h0, chan_latched});
      chan_on_cmd = 8'hFF;
      @(negedge clk);
      chan_on_cmd = 8'h00;
      wait_free(k);
    end
    ch = $urandom % PFR_NCH;
    i_pfr_host_model.wr(PFR_CMD_TON_MAX, 8'h88);
    for (int i = 0; i < 3; i++) begin
      fire(4, 8'h01 << ch);
      chk("ton_off", 16'h0001, {15'h0, snap_off[ch] | snap_seq[ch]});
      chk("ton_word", 16'h8001, status_word);
      chk("ton_flag", {8'h0, 8'h01 << ch}, {8'h0, ton_max_flags});
      chk("ton_alert", 16'h0001, {15'h0, host_alert_line_oe});
      watch(10, 8'h01 << ch);
      chk("retry", {15'h0, i < 2}, {15'h0, seen});
    end
    i_pfr_host_model.wr(PFR_CMD_CLEAR, 8'h00);
    i_pfr_host_model.wr(PFR_CMD_TON_MAX, 8'hC0);
    channel_on_pin[ch] = 1'h0;
    repeat (6) @(negedge clk);
    channel_on_pin[ch] = 1'h1;
    // Let the rising toggle settle before the next fault
    repeat (6) @(negedge clk);
    wait_free(ch);
    fire(4, 8'h01 << ch);
    watch(10, 8'h01 << ch);
    chk("ton_hold", 16'h0001, {14'h0, seen, chan_latched[ch]});
    i_pfr_host_model.wr(PFR_CMD_TON_MAX, 8'h48);
    chan_on_cmd = 8'h01 << ch;
    @(negedge clk);
    chan_on_cmd = 8'h00;
    wait_free(ch);
    bias_ok = 1'h0;
    repeat (6) @(negedge clk);
    fire(4, 8'h01 << ch);
    watch(10, 8'h01 << ch);
    chk("bias_stop", 16'h0000, {15'h0, seen});
    bias_ok = 1'h1;
    wait_free(ch);
    end_of_test();
  end
endmodule : pfr_fault_resp_tb

// *** verif/pfr_host_model.sv ***
// Host controller model issuing reaction commands and reading them back
`timescale 1ns/10ps
module pfr_host_model (
  input  wire logic       clk,
  output      logic       cmd_wr,
  output      logic       cmd_rd,
  output      logic [7:0] cmd_code,
  output      logic [7:0] cmd_data,
  input  wire logic [7:0] rd_data
);
  initial begin
    cmd_wr   = 1'h0;
    cmd_rd   = 1'h0;
    cmd_code = 8'hFF;
    cmd_data = 8'hA5;
  end
  task automatic wr(input logic [7:0] code, input logic [7:0] data);
    @(negedge clk);
    cmd_wr   = 1'h1;
    cmd_code = code;
    cmd_data = data;
    @(negedge clk);
    cmd_wr   = 1'h0;
    // Released lines show the inverse so a stale value never looks valid
    cmd_code = ~code;
    cmd_data = ~data;
  endtask : wr
  task automatic rd(input logic [7:0] code, output logic [7:0] data);
    @(negedge clk);
    cmd_rd   = 1'h1;
    cmd_code = code;
    @(negedge clk);
    cmd_rd   = 1'h0;
    cmd_code = ~code;
    data     = rd_data;
  endtask : rd
endmodule : pfr_host_model
